// File: fio_pkg.sv
package fio_pkg;

  // Clock and watchdog timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int WD_UNIT_NS = 1_000_000;
  localparam int CYC_PER_MS = WD_UNIT_NS / CLK_PERIOD_NS;

  // Power-up contents of the stored parameters and fault word, rate index limit
  localparam logic [15:0] WD_DEFAULT_MS = 16'h0032;
  localparam logic [15:0] RATE_DEFAULT_IDX = 16'h0009;
  localparam logic [15:0] RATE_MAX_IDX = 16'h000B;
  localparam logic [31:0] NODE_ID_DEFAULT = 32'h0000_0000;
  localparam logic [15:0] FAULT_RESET = 16'h0001;

  // Baud per rate index, index 0 in the low slot
  localparam logic [11:0][23:0] BAUD_TABLE = {
    24'h98_9680, 24'h4C_4B40, 24'h26_25A0, 24'h13_12D0,
    24'h0E_1000, 24'h07_0800, 24'h03_8400, 24'h01_C200,
    24'h00_E100, 24'h00_9600, 24'h00_4B00, 24'h00_2580};

  // Parameter indices on the parameter port
  localparam logic [3:0] PAR_STORED_RATE = 4'h0;
  localparam logic [3:0] PAR_STORED_ID = 4'h1;
  localparam logic [3:0] PAR_WORK_ID = 4'h2;
  localparam logic [3:0] PAR_STORED_WD = 4'h3;
  localparam logic [3:0] PAR_WORK_WD = 4'h4;
  localparam logic [3:0] PAR_OUTPUT = 4'h5;
  localparam logic [3:0] PAR_INPUT = 4'h6;
  localparam logic [3:0] PAR_FAULT = 4'h7;
  localparam logic [3:0] PAR_STATUS = 4'h8;

  // Fault word bits
  localparam int FLT_WATCHDOG = 0;
  localparam int FLT_SHORT = 1;
  localparam int FLT_OVERTEMP = 2;
  localparam int FLT_FIELD = 3;

  // Status word bits
  localparam int ST_MODE_LO = 0;
  localparam int ST_SETUP = 2;
  localparam int ST_FIELD_OK = 3;
  localparam int ST_WD_ON = 4;
  localparam int ST_BANK_LO = 5;
  localparam int ST_RATE_LO = 8;

  // Process data modes
  localparam logic [1:0] MODE_IO = 2'h0;
  localparam logic [1:0] MODE_ANALOG = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h2;

  typedef enum logic {FIO_PH_LOAD, FIO_PH_RUN} fio_phase_t;

  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    logic [31:0] wdata;
  } fio_par_req_t;

  typedef struct packed {
    logic [31:0] in_word;
    logic [3:0][7:0] analog;
    logic [7:0] field_v;
    logic [1:0][15:0] enc;
    logic [1:0] mode;
  } fio_pd_rsp_t;

  typedef struct packed {
    logic [31:0] sync1_in;
    logic [31:0] sync2_in;
    logic [15:0] sync1_short;
    logic [15:0] sync2_short;
    logic [1:0] sync1_ot;
    logic [1:0] sync2_ot;
    logic [2:0] sync1_misc;
    logic [2:0] sync2_misc;
    logic [3:0] prev_enc;
    fio_phase_t phase;
    logic [15:0] stored_rate;
    logic [31:0] stored_id;
    logic [31:0] work_id;
    logic [15:0] stored_wd;
    logic [15:0] work_wd;
    logic [15:0] out_req;
    logic [15:0] short_latch;
    logic [1:0] bank_off;
    logic [15:0] fault;
    logic [15:0] wd_ms;
    logic [23:0] wd_pre;
    logic [15:0] field_out;
    logic [3:0] rate_idx;
    logic [23:0] baud;
    logic par_ack;
    logic [31:0] par_rdata;
    logic pd_valid;
    fio_pd_rsp_t pd_rsp;
    logic fw_accept;
    logic fw_reject;
  } fio_state_t;

endpackage

// File: fio_node.sv
// Operation
// - Watchdog expiry sets fault, outputs go off
// - Timeout in ms; 50 default; zero disables
// - Output writes ignored until watchdog fault cleared
// - Fault flag set at power-up; host clears
// - Power-up copies stored params into working
// - Working timeout write changes period directly
// - Stored index 0..11 picks link baud
// - Output, input, fault and status words
// - Three pd modes; mode 0 digital only
// - Mode 1 adds four analog readings
// - Mode 2 adds field volts; 1X encoders in every mode
// - Analog readings 8 bits, 36.3V full scale
// - Separate supply: report field voltage loss
// - Outputs in two banks of eight
// - Firmware update accepted in setup only
// - Short circuit: that output off, fault
// - Overtemperature: whole bank off, fault
`timescale 1ns/1ps
`default_nettype none

module fio_node import fio_pkg::*; #(
  parameter int P_CYC_PER_MS = CYC_PER_MS
) (
  // Clock and power-up reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Field pins
  input wire logic [31:0] i_field_in,
  input wire logic [15:0] i_short,
  input wire logic [1:0] i_overtemp,
  input wire logic i_field_ok,
  input wire logic i_supply_separate,
  input wire logic i_setup_mode,
  output logic [15:0] o_field_out,
  // Converter codes, 8 bits each
  input wire logic [3:0][7:0] i_analog,
  input wire logic [7:0] i_field_v,
  // Process data exchange
  input wire logic i_pd_valid,
  input wire logic [15:0] i_pd_out,
  input wire logic [1:0] i_pd_mode,
  output logic o_pd_valid,
  output fio_pd_rsp_t o_pd_rsp,
  // Parameter access
  input wire logic i_par_req,
  input wire fio_par_req_t i_par,
  output logic o_par_ack,
  output logic [31:0] o_par_rdata,
  // Firmware image write
  input wire logic i_fw_req,
  output logic o_fw_accept,
  output logic o_fw_reject,
  // Link rate and state
  output logic [3:0] o_rate_idx,
  output logic [23:0] o_baud,
  output logic [15:0] o_fault
);

  // Prescale must fit the 24-bit counter, refused at elaboration
  if (P_CYC_PER_MS < 1 || P_CYC_PER_MS > 16_777_215) begin : g_bad_prescale
    $error("P_CYC_PER_MS out of range");
  end

  localparam logic [23:0] PRE_LOAD = 24'(P_CYC_PER_MS - 1);

  fio_state_t q;
  fio_state_t next_q;

  // Next state of the whole node
  always_comb begin
    logic [15:0] clr;
    logic [15:0] set;
    logic [15:0] allow;
    logic [15:0] status;
    logic par_wr;
    logic wd_fault;
    logic field_ok;
    logic setup;
    logic [1:0] a_now;
    logic [1:0] a_old;
    next_q = q;
    clr = '0;
    set = '0;
    allow = '0;
    status = '0;
    a_now = '0;
    a_old = '0;
    par_wr = i_par_req && i_par.wr;
    // Second sync stage only is read by logic
    next_q.sync1_in = i_field_in;
    next_q.sync2_in = q.sync1_in;
    next_q.sync1_short = i_short;
    next_q.sync2_short = q.sync1_short;
    next_q.sync1_ot = i_overtemp;
    next_q.sync2_ot = q.sync1_ot;
    next_q.sync1_misc = {i_setup_mode, i_supply_separate, i_field_ok};
    next_q.sync2_misc = q.sync1_misc;
    field_ok = q.sync2_misc[0];
    setup = q.sync2_misc[2];
    wd_fault = q.fault[FLT_WATCHDOG];
    next_q.par_ack = 1'b0;
    next_q.pd_valid = 1'b0;
    next_q.fw_accept = 1'b0;
    next_q.fw_reject = 1'b0;

    // Stored parameters reach the working copies once after power-up
    if (q.phase == FIO_PH_LOAD) begin
      next_q.work_wd = q.stored_wd;
      next_q.work_id = q.stored_id;
      next_q.wd_ms = q.stored_wd;
      next_q.wd_pre = PRE_LOAD;
      if (q.stored_rate > RATE_MAX_IDX) begin
        next_q.rate_idx = RATE_DEFAULT_IDX[3:0]; // Out-of-range index falls back
      end else begin
        next_q.rate_idx = q.stored_rate[3:0];
      end
      next_q.baud = BAUD_TABLE[next_q.rate_idx];
      next_q.phase = FIO_PH_RUN;
    end

    // Parameter writes; stored values are never applied, reset restores their defaults
    if (par_wr) begin
      if (i_par.idx == PAR_STORED_RATE) begin
        next_q.stored_rate = i_par.wdata[15:0];
      end else if (i_par.idx == PAR_STORED_ID) begin
        next_q.stored_id = i_par.wdata;
      end else if (i_par.idx == PAR_WORK_ID) begin
        next_q.work_id = i_par.wdata;
      end else if (i_par.idx == PAR_STORED_WD) begin
        next_q.stored_wd = i_par.wdata[15:0];
      end else if (i_par.idx == PAR_WORK_WD) begin
        next_q.work_wd = i_par.wdata[15:0];
        next_q.wd_ms = i_par.wdata[15:0];
        next_q.wd_pre = PRE_LOAD;
      end else if (i_par.idx == PAR_OUTPUT) begin
        if (!wd_fault) begin
          next_q.out_req = i_par.wdata[15:0];
        end
      end else if (i_par.idx == PAR_FAULT) begin
        clr = i_par.wdata[15:0]; // Write one to clear
      end
    end

    // Exchange restarts the watchdog and carries output data
    if (i_pd_valid) begin
      next_q.wd_ms = next_q.work_wd; // A same-cycle timeout write counts
      next_q.wd_pre = PRE_LOAD;
      if (!wd_fault) begin
        next_q.out_req = i_pd_out;
      end
    end else if (q.phase == FIO_PH_RUN && q.work_wd != 16'h0000 && q.wd_ms != 16'h0000
                 && !(par_wr && i_par.idx == PAR_WORK_WD)) begin
      // Millisecond prescale then count down; zero timeout never bites
      if (q.wd_pre == 24'h00_0000) begin
        next_q.wd_pre = PRE_LOAD;
        next_q.wd_ms = q.wd_ms - 16'h0001;
        if (q.wd_ms == 16'h0001) begin
          set[FLT_WATCHDOG] = 1'b1;
        end
      end else begin
        next_q.wd_pre = q.wd_pre - 24'h00_0001;
      end
    end

    // Clearing a cause releases its latches; a new event below wins
    if (clr[FLT_SHORT]) begin
      next_q.short_latch = '0;
    end
    if (clr[FLT_OVERTEMP]) begin
      next_q.bank_off = '0;
    end

    // Output protection causes
    for (int i = 0; i < 16; i++) begin
      if (q.sync2_short[i] && q.field_out[i]) begin
        next_q.short_latch[i] = 1'b1;
        set[FLT_SHORT] = 1'b1;
      end
    end
    for (int b = 0; b < 2; b++) begin
      if (q.sync2_ot[b]) begin
        next_q.bank_off[b] = 1'b1;
        set[FLT_OVERTEMP] = 1'b1;
      end
    end
    if (q.sync2_misc[1] && !field_ok) begin
      set[FLT_FIELD] = 1'b1;
    end

    // Set wins over a clear in the same cycle
    next_q.fault = (q.fault & ~clr) | set;
    if (next_q.fault[FLT_WATCHDOG]) begin
      next_q.out_req = '0;
    end

    // Drive pins from request minus every protection mask
    for (int i = 0; i < 16; i++) begin
      allow[i] = !next_q.short_latch[i] && !next_q.bank_off[i / 8];
    end
    next_q.field_out = next_q.fault[FLT_WATCHDOG] ? 16'h0000 : (next_q.out_req & allow);

    // Hand-wheel encoders, 1X: count on A rise, B picks direction
    for (int e = 0; e < 2; e++) begin
      a_now[e] = q.sync2_in[16 + 2 * e];
      a_old[e] = q.prev_enc[2 * e];
      if (a_now[e] && !a_old[e]) begin
        if (q.sync2_in[17 + 2 * e]) begin
          next_q.pd_rsp.enc[e] = q.pd_rsp.enc[e] - 16'h0001;
        end else begin
          next_q.pd_rsp.enc[e] = q.pd_rsp.enc[e] + 16'h0001;
        end
      end
    end
    next_q.prev_enc = q.sync2_in[19:16];

    // Process data answer, content chosen by mode
    next_q.pd_rsp.in_word = q.sync2_in;
    next_q.pd_rsp.mode = i_pd_mode;
    next_q.pd_rsp.analog = '0;
    next_q.pd_rsp.field_v = 8'h00;
    if (i_pd_mode == MODE_ANALOG || i_pd_mode == MODE_FULL) begin
      next_q.pd_rsp.analog = i_analog;
    end
    if (i_pd_mode == MODE_FULL) begin
      next_q.pd_rsp.field_v = i_field_v;
    end
    next_q.pd_valid = i_pd_valid;

    // Status word
    status[ST_MODE_LO +: 2] = i_pd_mode;
    status[ST_SETUP] = setup;
    status[ST_FIELD_OK] = field_ok;
    status[ST_WD_ON] = (q.work_wd != 16'h0000);
    status[ST_BANK_LO +: 2] = q.bank_off;
    status[ST_RATE_LO +: 4] = q.rate_idx;

    // Parameter reads; unknown index reads zero
    if (i_par_req) begin
      next_q.par_ack = 1'b1;
      if (i_par.idx == PAR_STORED_RATE) begin
        next_q.par_rdata = {16'h0000, q.stored_rate};
      end else if (i_par.idx == PAR_STORED_ID) begin
        next_q.par_rdata = q.stored_id;
      end else if (i_par.idx == PAR_WORK_ID) begin
        next_q.par_rdata = q.work_id;
      end else if (i_par.idx == PAR_STORED_WD) begin
        next_q.par_rdata = {16'h0000, q.stored_wd};
      end else if (i_par.idx == PAR_WORK_WD) begin
        next_q.par_rdata = {16'h0000, q.work_wd};
      end else if (i_par.idx == PAR_OUTPUT) begin
        next_q.par_rdata = {16'h0000, q.out_req};
      end else if (i_par.idx == PAR_INPUT) begin
        next_q.par_rdata = q.sync2_in;
      end else if (i_par.idx == PAR_FAULT) begin
        next_q.par_rdata = {16'h0000, q.fault};
      end else if (i_par.idx == PAR_STATUS) begin
        next_q.par_rdata = {16'h0000, status};
      end else begin
        next_q.par_rdata = 32'h0000_0000;
      end
    end

    // Firmware writes only in setup mode, never while operating
    if (i_fw_req) begin
      next_q.fw_accept = setup;
      next_q.fw_reject = !setup;
    end
  end

  // State register; fault flag comes up set
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
      q.phase <= FIO_PH_LOAD;
      q.stored_rate <= RATE_DEFAULT_IDX;
      q.stored_id <= NODE_ID_DEFAULT;
      q.stored_wd <= WD_DEFAULT_MS;
      q.work_wd <= WD_DEFAULT_MS;
      q.wd_ms <= WD_DEFAULT_MS;
      q.rate_idx <= RATE_DEFAULT_IDX[3:0];
      q.baud <= BAUD_TABLE[RATE_DEFAULT_IDX[3:0]];
      q.fault <= FAULT_RESET;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign o_field_out = q.field_out;
  assign o_pd_valid = q.pd_valid;
  assign o_pd_rsp = q.pd_rsp;
  assign o_par_ack = q.par_ack;
  assign o_par_rdata = q.par_rdata;
  assign o_fw_accept = q.fw_accept;
  assign o_fw_reject = q.fw_reject;
  assign o_rate_idx = q.rate_idx;
  assign o_baud = q.baud;
  assign o_fault = q.fault;

endmodule // fio_node

`default_nettype wire

// File: fio_node_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fio_node_checker import fio_pkg::*; (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Requests and field side
  input wire logic i_pd_valid,
  input wire logic i_par_req,
  input wire fio_par_req_t i_par,
  input wire logic i_fw_req,
  input wire logic [15:0] i_short,
  input wire logic [1:0] i_overtemp,
  input wire logic i_field_ok,
  input wire logic i_supply_separate,
  // Answers
  input wire logic o_pd_valid,
  input wire fio_pd_rsp_t o_pd_rsp,
  input wire logic o_par_ack,
  input wire logic o_fw_accept,
  input wire logic o_fw_reject,
  input wire logic [3:0] o_rate_idx,
  input wire logic [23:0] o_baud,
  input wire logic [15:0] o_field_out,
  input wire logic [15:0] o_fault
);
  // One domain; reset mutes every check
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_pd_ans; i_pd_valid |=> o_pd_valid; endproperty
  a_pd_ans: assert property (p_pd_ans) else $error("exchange answer missing");
  property p_par_ans; i_par_req |=> o_par_ack; endproperty
  a_par_ans: assert property (p_par_ans) else $error("parameter ack missing");
  property p_fw; i_fw_req |=> (o_fw_accept != o_fw_reject); endproperty
  a_fw: assert property (p_fw) else $error("firmware answer wrong");
  property p_baud; o_baud == BAUD_TABLE[o_rate_idx]; endproperty
  a_baud: assert property (p_baud) else $error("baud does not match index");
  property p_mode0; o_pd_valid && o_pd_rsp.mode == MODE_IO |-> o_pd_rsp.analog == '0
    && o_pd_rsp.field_v == 8'h00; endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 carries analog");
  property p_wd_off; o_fault[0] |=> o_field_out == 16'h0000; endproperty
  a_wd_off: assert property (p_wd_off) else $error("outputs on under fault");
  // Only an explicit host write may drop the watchdog flag
  property p_clr; $fell(o_fault[0]) |-> $past(i_par_req && i_par.wr && i_par.idx == 4'h7
    && i_par.wdata[0]); endproperty
  a_clr: assert property (p_clr) else $error("fault flag dropped alone");
  property p_short; (i_short & o_field_out) != 16'h0000 |-> ##[1:5] o_fault[1]; endproperty
  a_short: assert property (p_short) else $error("short not flagged");
  property p_ot; i_overtemp[1] |-> ##[1:5] (o_fault[2] && o_field_out[15:8] == 8'h00);
  endproperty
  a_ot: assert property (p_ot) else $error("hot bank still on");
  property p_field; i_supply_separate && !i_field_ok |-> ##[1:5] o_fault[3]; endproperty
  a_field: assert property (p_field) else $error("field loss not flagged");
  // Main scenarios reached
  c_accept: cover property (o_fw_accept);
  c_clear: cover property ($fell(o_fault[0]));
  c_full: cover property (o_pd_valid && o_pd_rsp.mode == MODE_FULL);
endmodule // fio_node_checker
bind fio_node fio_node_checker chk (.i_core_clk, .i_resetn, .i_pd_valid, .i_par_req, .i_par,
  .i_fw_req, .i_short, .i_overtemp, .i_field_ok, .i_supply_separate, .o_pd_valid, .o_pd_rsp,
  .o_par_ack, .o_fw_accept, .o_fw_reject, .o_rate_idx, .o_baud, .o_field_out, .o_fault);
`default_nettype wire

// File: fio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fio_host_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Feed control
  input wire logic i_run,
  input wire logic [7:0] i_gap,
  input wire logic [15:0] i_word,
  // Exchange toward the node
  output logic o_pd_valid,
  output logic [15:0] o_pd_out
);
  logic [7:0] cnt;
  // Periodic exchange; stopping the feed models a dead host
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 8'h00;
      o_pd_valid <= 1'b0;
      o_pd_out <= 16'h0000;
    end else begin
      o_pd_valid <= i_run && cnt == i_gap;
      o_pd_out <= (i_run && cnt == i_gap) ? i_word : ~o_pd_out; // Junk between exchanges
      cnt <= (cnt == i_gap || !i_run) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule // fio_host_model
`default_nettype wire

// File: tb_fio_node.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fio_node import fio_pkg::*; ;
  logic clk, rstn, fok, sep, setup, fw, preq, pdv, run, opv, ack, acc, rej;
  logic [31:0] fin, rd;
  logic [15:0] shrt, word, pdo, out, flt;
  logic [1:0] ot, mode;
  logic [3:0] ridx;
  logic [23:0] baud;
  fio_par_req_t par_i;
  fio_pd_rsp_t rsp;
  int n_errors, checks_done, i, j;
  logic [3:0] ri [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9};
  logic [31:0] re [8] = '{32'h0000_0009, 0, 0, 32'h0000_0032, 32'h0000_0032, 0, 1, 0};
  fio_node #(.P_CYC_PER_MS(10)) uut (.i_core_clk(clk), .i_resetn(rstn), .i_field_in(fin),
    .i_short(shrt), .i_overtemp(ot), .i_field_ok(fok), .i_supply_separate(sep),
    .i_setup_mode(setup), .o_field_out(out), .i_analog(32'h2B1A_0907), .i_field_v(8'h5E),
    .i_pd_valid(pdv), .i_pd_out(pdo), .i_pd_mode(mode), .o_pd_valid(opv), .o_pd_rsp(rsp),
    .i_par_req(preq), .i_par(par_i), .o_par_ack(ack), .o_par_rdata(rd), .i_fw_req(fw),
    .o_fw_accept(acc), .o_fw_reject(rej), .o_rate_idx(ridx), .o_baud(baud), .o_fault(flt));
  fio_host_model host (.i_core_clk(clk), .i_resetn(rstn), .i_run(run), .i_gap(8'h13),
    .i_word(word), .o_pd_valid(pdv), .o_pd_out(pdo));
  // 125 MHz clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk) #1;
  endtask
  // Extra edge at the end so the strobe never rises twice in one step
  task automatic par(input logic w, input logic [3:0] x, input logic [31:0] d);
    preq = 1;
    par_i = '{wr: w, idx: x, wdata: d};
    cyc(1);
    preq = 0;
    chk("ack", 1, {31'h0, ack});
    cyc(1);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rstn = 0; fin = 0; shrt = 0; ot = 0; fok = 1; sep = 0; setup = 0; fw = 0;
    preq = 0; par_i = '0; run = 0; word = 16'hA5C3; mode = 2'h0;
    n_errors = 0; checks_done = 0;
    cyc(10);
    rstn = 1;
    cyc(2);
    for (i = 0; i < 8; i++) begin
      par(0, ri[i], 0);
      chk("param", re[i], rd);
    end
    chk("baud", 32'h0026_25A0, {8'h00, baud});
    par(1, 4'h5, 32'h0000_FFFF);
    chk("out", 0, {16'h0, out});
    par(1, 4'h3, 32'h0000_0007);
    par(1, 4'h0, 32'h0000_0003);
    par(0, 4'h4, 0);
    chk("wd", 32'h0000_0032, rd);
    chk("rate", 9, {28'h0, ridx});
    par(1, 4'h7, 32'h0000_0001);
    chk("clear", 0, {16'h0, flt});
    run = 1;
    fin = 32'h1230_5678;
    cyc(800);
    chk("fed", 32'h0000_A5C3, {flt, out});
    for (i = 0; i < 3; i++) begin
      mode = i[1:0];
      cyc(2);
      for (j = 0; j < 30 && opv !== 1'b1; j++) cyc(1);
      if (j == 30) begin
        n_errors++;
        print_verdict;
      end
      chk("in", 32'h1230_5678, rsp.in_word);
      chk("mode", i, {30'h0, rsp.mode});
      chk("an", i > 0 ? 32'h2B1A_0907 : 0, rsp.analog);
      chk("fv", i == 2 ? 32'h5E : 0, {24'h0, rsp.field_v});
    end
    // Three up counts on the first wheel, one down count on the second
    for (j = 0; j < 3; j++) begin
      fin[16] = 1; cyc(3); fin[16] = 0; cyc(3);
    end
    fin[19] = 1; cyc(3); fin[18] = 1; cyc(3);
    chk("enc", 32'hFFFF_0003, rsp.enc);
    shrt = 16'h0001; ot = 2'b10; sep = 1; fok = 0;
    cyc(8);
    chk("faults", 32'h000E_00C2, {flt, out});
    shrt = 0; ot = 0; fok = 1;
    cyc(4);
    chk("sticky", 32'h000E, {16'h0, flt});
    par(1, 4'h7, 32'h0000_000E);
    cyc(25);
    chk("resume", 32'h0000_A5C3, {flt, out});
    par(1, 4'h4, 32'h0000_0005);
    run = 0;
    for (i = 0; i < 200 && flt[0] !== 1'b1; i++) cyc(1);
    chk("bite", 1, {31'h0, i >= 38 && i <= 62});
    if (i == 200) print_verdict;
    cyc(1);
    chk("off", 32'h0001_0000, {flt, out});
    run = 1;
    cyc(45);
    chk("ignored", 0, {16'h0, out});
    par(1, 4'h4, 0);
    run = 0;
    par(1, 4'h7, 32'h0000_0001);
    cyc(700);
    chk("nobite", 0, {31'h0, flt[0]});
    fw = 1; cyc(1); fw = 0;
    chk("reject", 1, {30'h0, acc, rej});
    setup = 1; cyc(4);
    fw = 1; cyc(1); fw = 0;
    chk("accept", 2, {30'h0, acc, rej});
    par(0, 4'h8, 0);
    chk("status", 32'h0000_090E, rd);
    par(0, 4'h6, 0);
    chk("input", fin, rd);
    rstn = 0;
    cyc(2);
    chk("rst", 32'h0001_0000, {flt, out});
    rstn = 1;
    cyc(2);
    print_verdict;
  end
endmodule // tb_fio_node
`default_nettype wire
